// [rtl/conveyor_tracking_start_queue.sv]
// tracking start queue: queues part starts, tracks conveyor travel and
// gates lasing so each part is marked only inside the tracking window, or up to the marking window edge when pitch limited
// assumes a wishbone classic master, a marking engine that reports
// mark_done_i, and encoder / sensor inputs synchronous to clk_i
//
// Operation
// - lase only once target inside tracking window
// - next part arriving during lasing is skipped
// - queue up to 32 pending part starts
// - queue holds parts sensed before window entry
// - skipped entry discarded, continue with next
// - pulses per millimetre scale encoder pulses
// - encoderless uses constant speed, ignores resolution
// - edge limited: stop lasing leaving tracking window
// - pitch limited: lase until leaving marking window
// - both incomplete cases log too fast error
// - single phase pulses advance mark position
// - quadrature decodes direction, follows reversal
// - internal trigger makes starts every pitch
// - tracking works without any encoder
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module conveyor_tracking_start_queue (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // encoder and part sensor
    input wire logic encoder_phase_a_input,
    input wire logic encoder_phase_b_input,
    input wire logic part_start_input,
    // marking engine
    input wire logic mark_done_i,
    output logic lase_o,
    output logic mark_start_o,
    // interrupt
    output logic irq_o
);
    import trk_pkg::*;

    typedef struct packed {
        trk_state_t st;                 // sequencer state
        logic ack;                      // bus answer
        logic [31:0] rdat;              // read data
        logic [CTL_W-1:0] ctrl;         // mode bits
        logic [15:0] res;               // encoder pulses per mm
        logic [15:0] spd;               // clock cycles per mm, encoderless
        logic [15:0] pitch;             // internal trigger pitch in mm
        logic [15:0] sdist;             // travel until fully in window
        logic [15:0] twin;              // tracking window length
        logic [15:0] mext;              // marking window beyond tracking
        logic [STS_W-1:0] sts;          // sticky events
        logic [STS_W-1:0] msk;          // interrupt mask
        logic [15:0] pos;               // conveyor position in mm
        logic [15:0] acc;               // pulses within the current mm
        logic [15:0] tick;              // cycles within the current mm
        logic [15:0] trig;              // position of last internal start
        logic sen;                      // sensor level last cycle
        logic [QDEPTH-1:0][15:0] stamp; // position each part was sensed
        logic [4:0] rd;                 // oldest entry
        logic [4:0] wr;                 // next free entry
        logic [5:0] cnt;                // entries held
        logic [15:0] cur;               // stamp of the part being lased
        logic lase;                     // lasing gate
        logic mstart;                   // start pulse to engine
        logic irq;                      // interrupt line
    } trk_t;

    trk_t q, d;

    logic enc_step;       // one encoder step
    logic enc_back;       // that step was backwards
    logic en;             // tracking enabled
    logic bus_req;        // fresh bus request
    logic sts_rd;         // status read this cycle
    logic push;           // a part start arrives
    logic pop;            // head entry consumed
    logic head_in;        // head part fully inside the window
    logic itrig;          // internal trigger fires
    logic [15:0] hd;      // head travel since sensing
    logic [15:0] ct;      // current part travel
    logic [15:0] limit;   // travel at which lasing must end
    logic [STS_W-1:0] ev; // events this cycle

    ////////////////////////////////////////////////////////////////////
    // encoder front end
    enc_decode u_dec (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .encoder_phase_a_input(encoder_phase_a_input),
        .encoder_phase_b_input(encoder_phase_b_input),
        .quad_i(q.ctrl[CTL_QUAD]),
        .step_o(enc_step),
        .back_o(enc_back)
    );

    // byte-lane merge for register writes
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // one next-state process for the whole block
    always_comb begin
        d = q;
        en = q.ctrl[CTL_EN];
        bus_req = wb_cyc_i && wb_stb_i && !q.ack;
        sts_rd = bus_req && !wb_we_i && (wb_adr_i == OFS_STATUS);
        ev = '0;
        push = 1'b0;
        pop = 1'b0;
        d.mstart = 1'b0;
        d.ack = bus_req;

        // ---------------- bus slave ----------------
        if (bus_req && wb_we_i) begin
            // unmapped writes are acknowledged and ignored
            if (wb_adr_i == OFS_CTRL) begin
                d.ctrl = CTL_W'(wmerge({27'd0, q.ctrl}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == OFS_RES) begin
                d.res = 16'(wmerge({16'd0, q.res}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == OFS_SPEED) begin
                d.spd = 16'(wmerge({16'd0, q.spd}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == OFS_PITCH) begin
                d.pitch = 16'(wmerge({16'd0, q.pitch}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == OFS_SDIST) begin
                d.sdist = 16'(wmerge({16'd0, q.sdist}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == OFS_TWIN) begin
                d.twin = 16'(wmerge({16'd0, q.twin}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == OFS_MEXT) begin
                d.mext = 16'(wmerge({16'd0, q.mext}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == OFS_MASK) begin
                d.msk = STS_W'(wmerge({28'd0, q.msk}, wb_dat_i, wb_sel_i));
            end
        end
        if (bus_req && !wb_we_i) begin
            // unmapped reads return zero
            if (wb_adr_i == OFS_CTRL) begin
                d.rdat = {27'd0, q.ctrl};
            end else if (wb_adr_i == OFS_RES) begin
                d.rdat = {16'd0, q.res};
            end else if (wb_adr_i == OFS_SPEED) begin
                d.rdat = {16'd0, q.spd};
            end else if (wb_adr_i == OFS_PITCH) begin
                d.rdat = {16'd0, q.pitch};
            end else if (wb_adr_i == OFS_SDIST) begin
                d.rdat = {16'd0, q.sdist};
            end else if (wb_adr_i == OFS_TWIN) begin
                d.rdat = {16'd0, q.twin};
            end else if (wb_adr_i == OFS_MEXT) begin
                d.rdat = {16'd0, q.mext};
            end else if (wb_adr_i == OFS_STATUS) begin
                d.rdat = {28'd0, q.sts};
            end else if (wb_adr_i == OFS_MASK) begin
                d.rdat = {28'd0, q.msk};
            end else if (wb_adr_i == OFS_QSTAT) begin
                d.rdat = {q.pos, 7'd0, q.lase, 2'd0, q.cnt};
            end else begin
                d.rdat = 32'h0000_0000;
            end
        end

        // ---------------- conveyor position ----------------
        if (q.ctrl[CTL_ENCLESS]) begin
            // constant speed: one mm every spd cycles, resolution unused
            d.acc = '0;
            if (q.tick + 16'd1 >= q.spd) begin
                d.tick = '0;
                d.pos = q.pos + 16'd1;
            end else begin
                d.tick = q.tick + 16'd1;
            end
        end else if (enc_step && !enc_back) begin
            // a zero resolution behaves as one pulse per mm
            if (q.acc + 16'd1 >= q.res) begin
                d.acc = '0;
                d.pos = q.pos + 16'd1;
            end else begin
                d.acc = q.acc + 16'd1;
            end
        end else if (enc_step) begin
            // reverse motion walks the position back
            if (q.acc == 16'd0) begin
                d.acc = (q.res == 16'd0) ? 16'd0 : q.res - 16'd1;
                d.pos = q.pos - 16'd1;
            end else begin
                d.acc = q.acc - 16'd1;
            end
        end

        // ---------------- part starts ----------------
        d.sen = part_start_input;
        itrig = q.ctrl[CTL_ITRIG] && (q.pitch != 16'd0)
            && ($signed(q.pos - q.trig) >= $signed(q.pitch));
        if (itrig) begin
            d.trig = q.pos;
        end
        if (q.ctrl[CTL_ITRIG]) begin
            push = en && itrig;
        end else begin
            push = en && part_start_input && !q.sen;
        end

        // head travel since it passed the sensor; signed so reversal is safe
        hd = q.pos - q.stamp[q.rd];
        ct = q.pos - q.cur;
        head_in = (q.cnt != 6'd0) && ($signed(hd) >= $signed(q.sdist));
        // edge limited stops at the tracking window edge, pitch limited
        // runs on to the marking window edge
        limit = q.sdist + q.twin;
        if (q.ctrl[CTL_PITCHLIM]) begin
            limit = q.sdist + q.twin + q.mext;
        end

        // ---------------- sequencer ----------------
        case (q.st)
            ST_IDLE: begin
                if (head_in) begin
                    pop = 1'b1;
                    d.cur = q.stamp[q.rd];
                    d.lase = 1'b1;
                    d.mstart = 1'b1;
                    d.st = ST_LASE;
                end
            end
            ST_LASE: begin
                if (head_in) begin
                    // next part reached the window while still lasing
                    pop = 1'b1;
                    ev[STS_MISSED] = 1'b1;
                end
                if (mark_done_i) begin
                    d.lase = 1'b0;
                    ev[STS_DONE] = 1'b1;
                    d.st = ST_IDLE;
                end else if ($signed(ct) >= $signed(limit)) begin
                    d.lase = 1'b0;
                    ev[STS_TOOFAST] = 1'b1;
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // ---------------- queue ----------------
        // entries are kept in arrival order, one per accepted part start
        if (pop) begin
            d.rd = q.rd + 5'd1;
        end
        if (push && (q.cnt == QFULL) && !pop) begin
            ev[STS_OVFL] = 1'b1;
            push = 1'b0;
        end
        if (push) begin
            d.stamp[q.wr] = q.pos;
            d.wr = q.wr + 5'd1;
        end
        d.cnt = q.cnt + {5'd0, push} - {5'd0, pop};

        // disabled: flush queue and stop lasing
        if (!en) begin
            d.rd = '0;
            d.wr = '0;
            d.cnt = '0;
            d.lase = 1'b0;
            d.mstart = 1'b0;
            d.st = ST_IDLE;
            ev = '0;
        end

        // ---------------- interrupt ----------------
        // a read clears status, an event in the same cycle still sets it
        d.sts = (sts_rd ? '0 : q.sts) | ev;
        d.irq = |(d.sts & d.msk);

        if (rst_i) begin
            d = '0;
            d.st = ST_IDLE;
            d.res = RES_RST;
            d.spd = SPEED_RST;
            d.pitch = PITCH_RST;
            d.sdist = SDIST_RST;
            d.twin = TWIN_RST;
            d.mext = MEXT_RST;
        end
    end

    // the only state register of the block
    always_ff @(posedge clk_i) begin
        q <= d;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign lase_o = q.lase;
    assign mark_start_o = q.mstart;
    assign irq_o = q.irq;

    ////////////////////////////////////////////////////////////////////
    // checks
    AST_START_IN_WINDOW: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(lase_o) |-> $past(head_in) && mark_start_o)
        else $error("lasing began before the part was inside the window");

    AST_QUEUE_BOUND: assert property (@(posedge clk_i) disable iff (rst_i)
        q.cnt <= QFULL)
        else $error("queue holds more than its depth");

    AST_SKIP_LOGGED: assert property (@(posedge clk_i) disable iff (rst_i)
        en && q.st == ST_LASE && head_in |=> q.sts[STS_MISSED])
        else $error("skipped part left no missed start flag");

    AST_SKIP_DISCARDS: assert property (@(posedge clk_i) disable iff (rst_i)
        en && q.st == ST_LASE && head_in && !push |=> q.cnt == $past(q.cnt) - 6'd1)
        else $error("skipped entry was not discarded");

    AST_OVERFLOW_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
        en && q.cnt == QFULL && !pop && !q.ctrl[CTL_ITRIG] && part_start_input && !q.sen
        |=> q.cnt == QFULL && q.sts[STS_OVFL] && q.wr == $past(q.wr))
        else $error("start into a full queue was not dropped");

    AST_WINDOW_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
        en && q.st == ST_LASE && !mark_done_i && $signed(ct) >= $signed(limit)
        |=> !lase_o && q.sts[STS_TOOFAST] ##1 !lase_o || mark_start_o)
        else $error("lasing did not stop at the window limit");

    AST_ENCLESS_RATE: assert property (@(posedge clk_i) disable iff (rst_i)
        q.ctrl[CTL_ENCLESS] && $past(q.ctrl[CTL_ENCLESS])
        |-> (q.pos - $past(q.pos)) inside {16'd0, 16'd1})
        else $error("encoderless position moved by more than one");

    AST_RES_SCALE: assert property (@(posedge clk_i) disable iff (rst_i)
        !q.ctrl[CTL_ENCLESS] && enc_step && !enc_back && q.acc + 16'd1 < q.res
        |=> q.pos == $past(q.pos) && q.acc == $past(q.acc) + 16'd1)
        else $error("pulse advanced position before a full millimetre");

    AST_ITRIG_PITCH: assert property (@(posedge clk_i) disable iff (rst_i)
        en && q.ctrl[CTL_ITRIG] && itrig |=> q.trig == $past(q.pos))
        else $error("internal trigger did not restart its pitch");
endmodule

// [rtl/trk_pkg.sv]
// constants shared by the tracking start queue and its self-checking bench
// assumes a single 125 MHz clock and a classic wishbone register port
package trk_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RES = 8'h04;
    localparam logic [7:0] OFS_SPEED = 8'h08;
    localparam logic [7:0] OFS_PITCH = 8'h0C;
    localparam logic [7:0] OFS_SDIST = 8'h10;
    localparam logic [7:0] OFS_TWIN = 8'h14;
    localparam logic [7:0] OFS_MEXT = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_MASK = 8'h20;
    localparam logic [7:0] OFS_QSTAT = 8'h24;
    // control bit positions
    localparam int CTL_EN = 0;
    localparam int CTL_QUAD = 1;
    localparam int CTL_ENCLESS = 2;
    localparam int CTL_ITRIG = 3;
    localparam int CTL_PITCHLIM = 4;
    localparam int CTL_W = 5;
    // status bit positions
    localparam int STS_MISSED = 0;
    localparam int STS_TOOFAST = 1;
    localparam int STS_OVFL = 2;
    localparam int STS_DONE = 3;
    localparam int STS_W = 4;
    // values after reset
    localparam logic [15:0] RES_RST = 16'h000C;
    localparam logic [15:0] SPEED_RST = 16'h0100;
    localparam logic [15:0] PITCH_RST = 16'h0064;
    localparam logic [15:0] SDIST_RST = 16'h0032;
    localparam logic [15:0] TWIN_RST = 16'h005A;
    localparam logic [15:0] MEXT_RST = 16'h0000;
    // queue depth of pending part starts
    localparam int QDEPTH = 32;
    localparam logic [5:0] QFULL = 6'd32;
    // tracking sequencer states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_LASE = 1'b1
    } trk_state_t;
endpackage

// [rtl/enc_decode.sv]
// encoder front end: turns phase a / phase b into one-step pulses
// assumes both phases are already synchronous to clk_i
`timescale 1ns/10ps
module enc_decode (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // encoder phases and mode
    input wire logic encoder_phase_a_input,
    input wire logic encoder_phase_b_input,
    input wire logic quad_i,
    // decoded motion
    output logic step_o,
    output logic back_o
);
    typedef struct packed {
        logic [1:0] ab;   // phases seen last cycle
        logic step;       // one step this cycle
        logic back;       // step was backwards
    } dec_t;

    dec_t q, d;
    logic [3:0] tr;       // previous and present phase pair

    ////////////////////////////////////////////////////////////////////
    // next state: single phase counts rising a edges, quadrature decodes
    always_comb begin
        tr = {q.ab, encoder_phase_a_input, encoder_phase_b_input};
        d = q;
        d.ab = tr[1:0];
        d.step = 1'b0;
        d.back = 1'b0;
        if (quad_i) begin
            // gray sequence 00-10-11-01 is forward, the reverse is backward
            case (tr)
                4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
                    d.step = 1'b1;
                end
                4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
                    d.step = 1'b1;
                    d.back = 1'b1;
                end
                default: begin
                    // no change or an illegal double jump; dropped
                    d.step = 1'b0;
                end
            endcase
        end else if (!q.ab[1] && encoder_phase_a_input) begin
            d.step = 1'b1;
        end
        if (rst_i) begin
            d = '0;
        end
    end

    // single state register
    always_ff @(posedge clk_i) begin
        q <= d;
    end

    assign step_o = q.step;
    assign back_o = q.back;

    AST_SINGLE_FORWARD: assert property (@(posedge clk_i) disable iff (rst_i)
        !quad_i && $rose(encoder_phase_a_input) |=> step_o && !back_o)
        else $error("single phase edge gave no forward step");
endmodule

// [bench/enc_part_model.sv]
// far side of the tracking block: incremental encoder and part sensor
// assumes the bench calls its tasks right after a rising edge of clk_i
`timescale 1ns/10ps
module enc_part_model (
    // clock
    input wire logic clk_i,
    // encoder phases and part sensor
    output logic phase_a_o,
    output logic phase_b_o,
    output logic part_o
);
    // quadrature position 0..3 in forward gray order 00,10,11,01
    int qpos;
    initial begin
        phase_a_o = 1'b0;
        phase_b_o = 1'b0;
        part_o = 1'b0;
        qpos = 0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // each level is held 3 cycles, so edges stay far below the rate limit
    task automatic hold3();
        repeat (3) @(posedge clk_i);
    endtask
    // one incremental pulse on phase a only
    task automatic pulse_a();
        phase_a_o <= 1'b1;
        hold3();
        phase_a_o <= 1'b0;
        hold3();
    endtask
    // one gray step; a wrong order would look like a double jump
    task automatic quad_step(input bit fwd);
        qpos = (qpos + (fwd ? 1 : 3)) % 4;
        phase_a_o <= (qpos == 1 || qpos == 2);
        phase_b_o <= (qpos >= 2);
        hold3();
    endtask
    // one rising edge per part, with low time after it
    task automatic part_pulse();
        part_o <= 1'b1;
        hold3();
        part_o <= 1'b0;
        hold3();
    endtask
endmodule

// [bench/tb.sv]
// self-checking bench for the tracking start queue
// assumes the far-side model is compiled before this file
`timescale 1ns/10ps
module tb;
    import trk_pkg::*;
    // design inputs, all valued at time zero
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic mark_done_i = 1'b0;
    // design outputs and far-side lines
    logic [31:0] wb_dat_o;
    logic wb_ack_o, lase_o, mark_start_o, irq_o, enc_a, enc_b, part_s;
    // counters and model state
    int fails = 0;
    int checks_done = 0;
    int starts = 0;
    int pulses = 0;
    logic [31:0] rd;
    logic [31:0] rnd = 32'h0000_22a2;
    logic [15:0] p0;
    logic [7:0] ofs [7] = '{OFS_CTRL, OFS_RES, OFS_SPEED, OFS_PITCH, OFS_SDIST,
        OFS_TWIN, OFS_QSTAT};
    logic [15:0] rv [7] = '{16'h0000, RES_RST, SPEED_RST, PITCH_RST, SDIST_RST,
        TWIN_RST, 16'h0000};
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    conveyor_tracking_start_queue i_conveyor_tracking_start_queue (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .encoder_phase_a_input(enc_a),
        .encoder_phase_b_input(enc_b), .part_start_input(part_s),
        .mark_done_i(mark_done_i), .lase_o(lase_o), .mark_start_o(mark_start_o),
        .irq_o(irq_o));
    enc_part_model i_enc_part_model (.clk_i(clk_i), .phase_a_o(enc_a),
        .phase_b_o(enc_b), .part_o(part_s));
    // count start pulses; each lasts one cycle
    always @(posedge clk_i) begin
        if (mark_start_o === 1'b1) begin
            starts++;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    // galois shift register for write data
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction
    // classic single cycle; read data is taken at the ack edge only
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int i;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        for (i = 0; i < 16; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (i == 16) begin
            fails++;
            complete_run();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // move the conveyor n encoder steps; the model counts raw pulses
    task automatic move(input int n, input bit quad, input bit fwd);
        for (int k = 0; k < n; k++) begin
            if (quad) begin
                i_enc_part_model.quad_step(fwd);
            end else begin
                i_enc_part_model.pulse_a();
            end
            pulses += fwd ? 1 : -1;
        end
    endtask
    // finish the current mark with a one-cycle done
    task automatic done();
        mark_done_i <= 1'b1;
        @(posedge clk_i);
        mark_done_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // cut a hang short
    initial begin
        repeat (100000) @(posedge clk_i);
        fails++;
        complete_run();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int k = 0; k < 7; k++) begin
            wb(1'b0, ofs[k], 32'h0000_0000);
            chk("reset value", {16'h0000, rv[k]}, rd);
        end
        rnd = lfsr(rnd);
        wb(1'b1, OFS_MEXT, rnd);
        wb(1'b0, OFS_MEXT, 32'h0000_0000);
        chk("mark extension", {16'h0000, rnd[15:0]}, rd);
        wb(1'b1, 8'h40, rnd);
        wb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        // two pulses per millimetre, single phase then quadrature
        wb(1'b1, OFS_RES, 32'h0000_0002);
        move(4, 1'b0, 1'b1);
        wb(1'b0, OFS_QSTAT, 32'h0000_0000);
        chk("position", 32'(pulses / 2), {16'h0000, rd[31:16]});
        wb(1'b1, OFS_CTRL, 32'h0000_0002);
        move(4, 1'b1, 1'b1);
        move(4, 1'b1, 1'b0);
        wb(1'b0, OFS_QSTAT, 32'h0000_0000);
        chk("position", 32'(pulses / 2), {16'h0000, rd[31:16]});
        // fill the queue past its depth while nothing can lase
        wb(1'b1, OFS_SDIST, 32'h0000_0064);
        wb(1'b1, OFS_CTRL, 32'h0000_0001);
        for (int k = 0; k < QDEPTH + 1; k++) begin
            i_enc_part_model.part_pulse();
        end
        wb(1'b0, OFS_QSTAT, 32'h0000_0000);
        chk("queue count", 32'(QDEPTH), {26'h0, rd[5:0]});
        wb(1'b1, OFS_MASK, 32'h0000_0004);
        chk_bit("irq", 1'b1, irq_o);
        wb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0004, rd);
        @(posedge clk_i);
        chk_bit("irq", 1'b0, irq_o);
        // flush, then a second part reaches the window while the first is lasing
        wb(1'b1, OFS_CTRL, 32'h0000_0000);
        wb(1'b1, OFS_SDIST, 32'h0000_0002);
        wb(1'b1, OFS_CTRL, 32'h0000_0001);
        i_enc_part_model.part_pulse();
        move(2, 1'b0, 1'b1);
        chk_bit("lase", 1'b0, lase_o);
        i_enc_part_model.part_pulse();
        move(2, 1'b0, 1'b1);
        chk_bit("lase", 1'b1, lase_o);
        move(2, 1'b0, 1'b1);
        wb(1'b0, OFS_QSTAT, 32'h0000_0000);
        chk("queue count", 32'h0000_0000, {26'h0, rd[5:0]});
        done();
        chk_bit("lase", 1'b0, lase_o);
        wb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0009, rd);
        // a part that outruns the tracking window
        wb(1'b1, OFS_TWIN, 32'h0000_0001);
        i_enc_part_model.part_pulse();
        move(4, 1'b0, 1'b1);
        chk_bit("lase", 1'b1, lase_o);
        move(2, 1'b0, 1'b1);
        chk_bit("lase", 1'b0, lase_o);
        wb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0002, rd);
        chk("mark starts", 32'h0000_0002, 32'(starts));
        // encoderless: 20 cycles per mm for 200 cycles, resolution ignored
        wb(1'b1, OFS_SPEED, 32'h0000_0014);
        wb(1'b1, OFS_CTRL, 32'h0000_0005);
        wb(1'b0, OFS_QSTAT, 32'h0000_0000);
        p0 = rd[31:16];
        repeat (194) @(posedge clk_i);
        wb(1'b0, OFS_QSTAT, 32'h0000_0000);
        p0 = rd[31:16] - p0;
        chk_bit("speed travel", 1'b1, (p0 >= 16'd9 && p0 <= 16'd11));
        // internal trigger: one start per 2 mm, sensor ignored
        wb(1'b1, OFS_SDIST, 32'h0000_0064);
        wb(1'b1, OFS_PITCH, 32'h0000_0002);
        wb(1'b1, OFS_CTRL, 32'h0000_0008);
        wb(1'b1, OFS_CTRL, 32'h0000_0009);
        i_enc_part_model.part_pulse();
        move(8, 1'b0, 1'b1);
        wb(1'b0, OFS_QSTAT, 32'h0000_0000);
        chk("trigger count", 32'h0000_0002, {26'h0, rd[5:0]});
        // pitch limited: lasing runs on, the next part is skipped
        wb(1'b1, OFS_CTRL, 32'h0000_0000);
        wb(1'b1, OFS_SDIST, 32'h0000_0002);
        wb(1'b1, OFS_MEXT, 32'h0000_0002);
        wb(1'b1, OFS_CTRL, 32'h0000_0011);
        i_enc_part_model.part_pulse();
        move(2, 1'b0, 1'b1);
        i_enc_part_model.part_pulse();
        move(4, 1'b0, 1'b1);
        chk_bit("lase", 1'b1, lase_o);
        move(4, 1'b0, 1'b1);
        chk_bit("lase", 1'b0, lase_o);
        wb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0003, rd);
        complete_run();
    end
endmodule
